// ### logic/tckl_keyswitch.sv
// Control-section keyswitch logic with Avalon-MM register slave
//
// The Avalon-MM slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Notes on behaviour
// R1 - Attention key sends a break toward host
// R2 - Line control, transmitting: break on forward channel
// R3 - Line control, reverse, receiving: break on reverse
// R4 - Answerback key triggers stored identification message
// R5 - Reset key clears the error indicator
// R6 - Reset key also restores a faulted printer
// R7 - Auto line advance adds local LF after CR
// R8 - Double advance adds second unsent LF
// R9 - Capitals latch uppercases keyed letters
// R10 - Received characters printed unchanged
// R11 - Local latch: keyed characters print only
// R12 - Remote: send keyed, accept received characters
// R13 - Local release samples carrier: receive or transmit
// R14 - Reveal latch: head moves after half-second idle
// R15 - Reveal released: no delayed head move
// R16 - Page key: local form feed, nothing sent
// R17 - Momentary keys pulse once; latches are levels
// R18 - Only character key repeats, after delay
// ----------------------------------------
module tckl_keyswitch
  import tckl_pkg::*;
#(
  parameter int DEBOUNCE = DEBOUNCE_CYC,
  parameter int REVEAL = REVEAL_CYC,
  parameter int REP_DELAY = REPEAT_DELAY_CYC,
  parameter int REP_PERIOD = REPEAT_CYC,
  parameter int BUF_DEPTH = 2
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [NUM_KEYS-2:0] keys_raw,
  input wire logic char_key_down,
  input wire logic [7:0] char_key_code,
  input wire logic rx_valid,
  input wire tckl_item_type rx_data,
  output logic rx_ready,
  output logic tx_valid,
  output tckl_item_type tx_data,
  input wire logic tx_ready,
  output logic print_valid,
  output tckl_item_type print_data,
  input wire logic print_ready,
  output logic break_forward,
  output logic break_reverse,
  output logic answerback_start,
  output logic printer_restore,
  output logic head_reveal,
  output logic error_lamp,
  input wire logic error_detect,
  input wire logic printer_fault,
  input wire logic carrier_detect,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  localparam int RW = $clog2(REVEAL + 1);
  localparam int PW = $clog2(REP_DELAY + REP_PERIOD + 1);
  localparam int AW = $clog2(BUF_DEPTH);
  initial begin
    if (BUF_DEPTH < 2 || (1 << AW) != BUF_DEPTH) $error("BUF_DEPTH must be a power of two >= 2");
    if (REVEAL < 2 || REP_DELAY < 1 || REP_PERIOD < 1) $error("timing counts too small");
  end
  // ----------------------------------------
  // Debounce all keys
  // ----------------------------------------
  logic [NUM_KEYS-1:0] raw_all;
  logic [NUM_KEYS-1:0] lvl;
  logic [NUM_KEYS-1:0] prs;
  assign raw_all = {char_key_down, keys_raw};
  for (genvar i = 0; i < NUM_KEYS; i++) begin : g_deb
    tckl_debounce #(.CYCLES(DEBOUNCE)) u_deb (  // see R17
      .mclk(mclk),
      .nrst(nrst),
      .raw(raw_all[i]),
      .level(lvl[i]),
      .press(prs[i])
    );
  end
  logic remote;
  assign remote = !lvl[L_LOCAL];
  // ----------------------------------------
  // Control register and link state
  // ----------------------------------------
  logic [1:0] ctrl;
  logic [1:0] next_ctrl;
  tckl_link_type link_state;
  tckl_link_type next_link_state;
  logic local_prev;
  logic err;
  logic next_err;
  logic [3:0] pulses;
  logic [3:0] next_pulses;
  logic line_ctl;
  assign line_ctl = ctrl[CTRL_LINE_CONTROL];
  always_comb begin
    next_ctrl = ctrl;
    if (avs_write && avs_address == OFS_CTRL && !avs_waitrequest) begin
      next_ctrl = avs_writedata[1:0];
    end
    next_link_state = link_state;
    if (line_ctl && local_prev && !lvl[L_LOCAL]) begin
      next_link_state = carrier_detect ? LINK_RECV : LINK_XMIT;  // see R13
    end
    next_err = (err && !prs[K_RESET]) || error_detect;  // see R5
    next_pulses[0] = prs[K_BREAK] && !(line_ctl && ctrl[CTRL_REVERSE_CHAN]  // see R1 R2
      && link_state == LINK_RECV);
    next_pulses[1] = prs[K_BREAK] && line_ctl && ctrl[CTRL_REVERSE_CHAN]  // see R3
      && link_state == LINK_RECV;
    next_pulses[2] = prs[K_ANSWER];  // see R4
    next_pulses[3] = prs[K_RESET] && printer_fault;  // see R6
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= CTRL_RESET;
      link_state <= LINK_XMIT;
      local_prev <= 1'b0;
      err <= 1'b0;
      pulses <= '0;
    end else begin
      ctrl <= next_ctrl;
      link_state <= next_link_state;
      local_prev <= lvl[L_LOCAL];
      err <= next_err;
      pulses <= next_pulses;
    end
  end
  assign {printer_restore, answerback_start, break_reverse, break_forward} = pulses;
  assign error_lamp = err;
  // ----------------------------------------
  // Character key repeat and pending requests
  // ----------------------------------------
  logic [PW-1:0] rep_cnt;
  logic [PW-1:0] next_rep_cnt;
  logic kb_pend;
  logic next_kb_pend;
  logic [7:0] kb_code;
  logic [7:0] next_kb_code;
  logic pg_pend;
  logic next_pg_pend;
  logic fire;
  tckl_seq_type seq;
  tckl_seq_type next_seq;
  tckl_item_type cur;
  tckl_item_type next_cur;
  logic take;
  logic buf_in_ready;
  // Control keys never reach this counter, so they cannot repeat
  always_comb begin
    next_rep_cnt = '0;
    fire = prs[K_CHAR];
    if (lvl[K_CHAR]) begin
      next_rep_cnt = rep_cnt + 1'b1;
      if (rep_cnt == PW'(REP_DELAY + REP_PERIOD - 1)) begin  // see R18
        fire = 1'b1;
        next_rep_cnt = PW'(REP_DELAY);
      end
    end
  end
  always_comb begin
    next_kb_pend = kb_pend;
    next_kb_code = kb_code;
    next_pg_pend = pg_pend || prs[K_PAGE];
    if (seq == SEQ_IDLE && kb_pend) begin
      next_kb_pend = 1'b0;
    end else if (seq == SEQ_IDLE && pg_pend) begin
      next_pg_pend = prs[K_PAGE];
    end
    // A repeat while the sequencer is busy is queued in kb_pend; it is dropped only if a code is already pending
    if (fire && !next_kb_pend) begin
      next_kb_pend = 1'b1;
      next_kb_code = char_key_code;
    end
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rep_cnt <= '0;
      kb_pend <= 1'b0;
      kb_code <= 8'h00;
      pg_pend <= 1'b0;
    end else begin
      rep_cnt <= next_rep_cnt;
      kb_pend <= next_kb_pend;
      kb_code <= next_kb_code;
      pg_pend <= next_pg_pend;
    end
  end
  // ----------------------------------------
  // Print sequencer
  // ----------------------------------------
  logic is_lower;
  assign is_lower = kb_code >= CODE_LC_A && kb_code <= CODE_LC_Z;
  assign rx_ready = seq == SEQ_IDLE && !kb_pend && !pg_pend && remote;  // see R12
  assign take = buf_in_ready && !(cur.send && tx_valid);
  always_comb begin
    next_seq = seq;
    next_cur = cur;
    unique case (seq)
      SEQ_IDLE: begin
        if (kb_pend) begin
          next_cur.code = (lvl[L_CAPS] && is_lower) ? kb_code - CASE_OFFSET : kb_code;  // see R9
          next_cur.send = remote;  // see R11 R12
          next_seq = SEQ_MAIN;
        end else if (pg_pend) begin
          next_cur = '{send: 1'b0, code: CODE_FF};  // see R16
          next_seq = SEQ_MAIN;
        end else if (rx_valid && rx_ready) begin
          next_cur = '{send: 1'b0, code: rx_data.code};  // see R10
          next_seq = SEQ_MAIN;
        end
      end
      SEQ_MAIN: begin
        if (take) begin
          next_cur = '{send: 1'b0, code: CODE_LF};
          if (cur.code == CODE_CR && lvl[L_CRLF]) begin
            next_seq = SEQ_LF1;  // see R7
          end else if (cur.code == CODE_LF && lvl[L_DOUBLE]) begin
            next_seq = SEQ_LF2;  // see R8
          end else begin
            next_seq = SEQ_IDLE;
          end
        end
      end
      SEQ_LF1: begin
        if (take) begin
          next_seq = lvl[L_DOUBLE] ? SEQ_LF2 : SEQ_IDLE;  // see R8
        end
      end
      SEQ_LF2: begin
        if (take) begin
          next_seq = SEQ_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      seq <= SEQ_IDLE;
      cur <= '0;
    end else begin
      seq <= next_seq;
      cur <= next_cur;
    end
  end
  // ----------------------------------------
  // Link transmit holding register
  // ----------------------------------------
  logic next_tx_valid;
  tckl_item_type next_tx_data;
  always_comb begin
    next_tx_valid = tx_valid && !tx_ready;
    next_tx_data = tx_data;
    if (seq == SEQ_MAIN && take && cur.send) begin
      next_tx_valid = 1'b1;  // see R11
      next_tx_data = cur;
    end
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tx_valid <= 1'b0;
      tx_data <= '0;
    end else begin
      tx_valid <= next_tx_valid;
      tx_data <= next_tx_data;
    end
  end
  // ----------------------------------------
  // Two-entry print buffer
  // ----------------------------------------
  tckl_item_type mem [BUF_DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;
  assign buf_in_ready = (wr_ptr - rd_ptr) != (AW + 1)'(BUF_DEPTH);
  assign push = seq != SEQ_IDLE && take;
  assign print_valid = wr_ptr != rd_ptr;
  assign pop = print_valid && print_ready;
  assign print_data = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      for (int i = 0; i < BUF_DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else begin
      if (push) begin
        mem[wr_ptr[AW-1:0]] <= cur;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
  // ----------------------------------------
  // Delayed head reveal
  // ----------------------------------------
  logic [RW-1:0] idle_cnt;
  logic [RW-1:0] next_idle_cnt;
  logic revealed;
  logic next_revealed;
  logic next_head_reveal;
  always_comb begin
    next_idle_cnt = idle_cnt;
    next_revealed = revealed;
    next_head_reveal = 1'b0;
    if (pop || print_valid) begin
      next_idle_cnt = '0;
      next_revealed = 1'b0;
    end else if (!lvl[L_REVEAL]) begin
      next_idle_cnt = '0;  // see R15
    end else if (!revealed) begin
      next_idle_cnt = idle_cnt + 1'b1;
      if (idle_cnt == RW'(REVEAL - 1)) begin
        next_head_reveal = 1'b1;  // see R14
        next_revealed = 1'b1;
      end
    end
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      idle_cnt <= '0;
      revealed <= 1'b1;
      head_reveal <= 1'b0;
    end else begin
      idle_cnt <= next_idle_cnt;
      revealed <= next_revealed;
      head_reveal <= next_head_reveal;
    end
  end
  // ----------------------------------------
  // Avalon-MM slave, one wait state
  // ----------------------------------------
  logic ack;
  logic [31:0] next_readdata;
  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  always_comb begin
    next_readdata = 32'h0000_0000;
    if (avs_address == OFS_CTRL) begin
      next_readdata[1:0] = ctrl;
    end else if (avs_address == OFS_STATUS) begin
      next_readdata[ST_LATCH_LSB +: 5] = lvl[L_REVEAL:L_CRLF];
      next_readdata[ST_RECEIVING] = link_state == LINK_RECV;
      next_readdata[ST_ERROR] = err;
      next_readdata[ST_BUSY] = seq != SEQ_IDLE;
    end
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ack <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack <= (avs_read || avs_write) && !ack;
      avs_readdata <= next_readdata;
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence s_cr_taken;
    seq == SEQ_MAIN && take && cur.code == CODE_CR && lvl[L_CRLF];
  endsequence
  a_break_fwd: assert property (prs[K_BREAK] && !(line_ctl && ctrl[CTRL_REVERSE_CHAN]) |=> break_forward) else $error("break not sent forward"); // see R1 R2
  a_break_rev: assert property (prs[K_BREAK] && line_ctl && ctrl[CTRL_REVERSE_CHAN] && link_state == LINK_RECV |=> break_reverse && !break_forward) else $error("break not on reverse"); // see R3
  a_answer_pulse: assert property (prs[K_ANSWER] |=> answerback_start) else $error("answerback missing"); // see R4
  a_error_clear: assert property (err && prs[K_RESET] && !error_detect |=> !error_lamp) else $error("error lamp not cleared"); // see R5
  a_restore_pulse: assert property (prs[K_RESET] && printer_fault |=> printer_restore) else $error("printer not restored"); // see R6
  a_crlf_added: assert property (s_cr_taken |=> seq == SEQ_LF1 && cur.code == CODE_LF && !cur.send) else $error("no LF after CR"); // see R7
  a_double_lf: assert property (seq == SEQ_LF1 && take && lvl[L_DOUBLE] |=> seq == SEQ_LF2) else $error("second LF missing"); // see R8
  a_caps_force: assert property (seq == SEQ_IDLE && kb_pend && lvl[L_CAPS] && is_lower |=> cur.code == $past(kb_code) - CASE_OFFSET) else $error("not uppercased"); // see R9
  a_rx_unchanged: assert property (seq == SEQ_IDLE && !kb_pend && !pg_pend && rx_valid && rx_ready |=> cur.code == $past(rx_data.code)) else $error("rx changed"); // see R10
  a_local_silent: assert property (!remote && seq == SEQ_IDLE && kb_pend |=> !cur.send) else $error("local char sent"); // see R11
  a_carrier_sample: assert property (line_ctl && local_prev && !lvl[L_LOCAL] |=> link_state == (($past(carrier_detect)) ? LINK_RECV : LINK_XMIT)) else $error("carrier not sampled"); // see R13
  a_reveal_off: assert property (!lvl[L_REVEAL] |=> !head_reveal) else $error("reveal while released"); // see R15
  a_page_local: assert property (seq == SEQ_IDLE && !kb_pend && pg_pend |=> cur.code == CODE_FF && !cur.send) else $error("form feed sent"); // see R16
  a_press_once: assert property (prs[K_BREAK] |=> !prs[K_BREAK]) else $error("double press pulse"); // see R17
endmodule
`default_nettype wire

// ### logic/tckl_pkg.sv
// Package: constants, types and register map of the control keyswitch logic
package tckl_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int DEBOUNCE_US = 5000;
  localparam int DEBOUNCE_CYC = CLK_HZ / 1_000_000 * DEBOUNCE_US;
  localparam int REVEAL_MS = 500;
  localparam int REVEAL_CYC = CLK_HZ / 1000 * REVEAL_MS;
  localparam int REPEAT_DELAY_MS = 500;
  localparam int REPEAT_DELAY_CYC = CLK_HZ / 1000 * REPEAT_DELAY_MS;
  localparam int REPEAT_RATE_HZ = 20;
  localparam int REPEAT_CYC = CLK_HZ / REPEAT_RATE_HZ;
  // ----------------------------------------
  // Key indices in the debounced vector
  // ----------------------------------------
  localparam int NUM_KEYS = 10;
  localparam int K_BREAK = 0;
  localparam int K_ANSWER = 1;
  localparam int K_RESET = 2;
  localparam int K_PAGE = 3;
  localparam int L_CRLF = 4;
  localparam int L_DOUBLE = 5;
  localparam int L_CAPS = 6;
  localparam int L_LOCAL = 7;
  localparam int L_REVEAL = 8;
  localparam int K_CHAR = 9;
  // ----------------------------------------
  // Character codes
  // ----------------------------------------
  localparam logic [7:0] CODE_CR = 8'h0D;
  localparam logic [7:0] CODE_LF = 8'h0A;
  localparam logic [7:0] CODE_FF = 8'h0C;
  localparam logic [7:0] CODE_LC_A = 8'h61;
  localparam logic [7:0] CODE_LC_Z = 8'h7A;
  localparam logic [7:0] CASE_OFFSET = 8'h20;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam int CTRL_LINE_CONTROL = 0;
  localparam int CTRL_REVERSE_CHAN = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int ST_LATCH_LSB = 0;
  localparam int ST_RECEIVING = 5;
  localparam int ST_ERROR = 6;
  localparam int ST_BUSY = 7;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic send;
    logic [7:0] code;
  } tckl_item_type;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_MAIN = 2'b01,
    SEQ_LF1 = 2'b11,
    SEQ_LF2 = 2'b10
  } tckl_seq_type;
  typedef enum logic {
    LINK_XMIT = 1'b0,
    LINK_RECV = 1'b1
  } tckl_link_type;
endpackage

// ### logic/tckl_debounce.sv
// Single keyswitch debouncer with a press pulse
`timescale 1ns/1ps
`default_nettype none
module tckl_debounce
  import tckl_pkg::*;
#(
  parameter int CYCLES = DEBOUNCE_CYC
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic raw,
  output logic level,
  output logic press
);
  localparam int W = $clog2(CYCLES + 1);
  initial begin
    if (CYCLES < 1) $error("tckl_debounce: CYCLES must be at least 1");
  end
  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic next_level;
  logic next_press;
  // ----------------------------------------
  // Settle counter
  // ----------------------------------------
  always_comb begin
    next_count = '0;
    next_level = level;
    next_press = 1'b0;
    if (raw != level) begin
      if (count == W'(CYCLES - 1)) begin
        next_level = raw;
        next_press = raw;
      end else begin
        next_count = count + 1'b1;
      end
    end
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
      level <= 1'b0;
      press <= 1'b0;
    end else begin
      count <= next_count;
      level <= next_level;
      press <= next_press;
    end
  end
endmodule
`default_nettype wire

// ### tb/tckl_host_model.sv
// Model of the modem and host on the far side of the data link
`timescale 1ns/1ps
`default_nettype none
module tckl_host_model
  import tckl_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  output logic rx_valid,
  output tckl_item_type rx_data,
  input wire logic rx_ready,
  input wire logic tx_valid,
  output logic tx_ready
);
  // ----------------------------------------
  // Received-character source
  // ----------------------------------------
  logic [7:0] rx_q[$];

  task automatic queue_rx(input logic [7:0] code);
    rx_q.push_back(code);
  endtask

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rx_valid <= 1'b0;
      rx_data <= '0;
      tx_ready <= 1'b0;
    end else begin
      // Random stalls: the host is not always free to take a word
      tx_ready <= ($urandom % 4) != 0;
      if (rx_valid && rx_ready) begin
        rx_valid <= 1'b0;
        // Released data must not look like the last word
        rx_data <= ~rx_data;
      end else if (!rx_valid && rx_q.size() != 0) begin
        rx_valid <= 1'b1;
        rx_data <= '{send: 1'b0, code: rx_q.pop_front()};
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/tckl_keyswitch_tb.sv
// Self-checking bench of the control keyswitch logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin errors++; \
  $display("unexpected %s: expected %h seen %h", nm, ex, got); end end
module tckl_keyswitch_tb;
  import tckl_pkg::*;
  localparam int DB = 4;
  localparam int RV = 20;
  logic mclk = 1'b0, nrst = 1'b0, char_key_down = 1'b0, rx_ready, rx_valid, tx_valid, tx_ready;
  logic [NUM_KEYS-2:0] keys_raw = '0;
  logic [7:0] char_key_code = 8'h00, ch, ex_code;
  tckl_item_type rx_data, tx_data, print_data, ex_item;
  logic print_valid, print_ready = 1'b0, stall = 1'b0;
  logic break_forward, break_reverse, answerback_start, printer_restore, head_reveal;
  logic error_lamp, error_detect = 1'b0, printer_fault = 1'b0, carrier_detect = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd, rnd;
  int errors = 0, compares = 0, cyc = 0;
  int pulses[5] = '{0, 0, 0, 0, 0};
  logic [7:0] exp_tx[$];
  tckl_item_type exp_pr[$];

  always #50 mclk = ~mclk;

  tckl_keyswitch #(.DEBOUNCE(DB), .REVEAL(RV), .REP_DELAY(30), .REP_PERIOD(10), .BUF_DEPTH(2))
  i_dut (.mclk(mclk), .nrst(nrst), .keys_raw(keys_raw), .char_key_down(char_key_down),
    .char_key_code(char_key_code), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .print_valid(print_valid), .print_data(print_data), .print_ready(print_ready),
    .break_forward(break_forward), .break_reverse(break_reverse),
    .answerback_start(answerback_start), .printer_restore(printer_restore),
    .head_reveal(head_reveal), .error_lamp(error_lamp), .error_detect(error_detect),
    .printer_fault(printer_fault), .carrier_detect(carrier_detect),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  tckl_host_model i_host (.mclk(mclk), .nrst(nrst), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_ready(tx_ready));

  // ----------------------------------------
  // Monitors: streams against notes, pulse counts
  // ----------------------------------------
  always @(posedge mclk) begin
    if (nrst) begin
      print_ready <= stall ? 1'b0 : (($urandom % 3) != 0);
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
        if (exp_tx.size() == 0) begin
          errors++;
          $display("unexpected tx_data: expected none seen %h", tx_data.code);
        end else begin
          ex_code = exp_tx.pop_front();
          `CHK("tx_data", ex_code, tx_data.code)
        end
      end
      if (print_valid === 1'b1 && print_ready === 1'b1) begin
        if (exp_pr.size() == 0) begin
          errors++;
          $display("unexpected print_data: expected none seen %h", print_data);
        end else begin
          ex_item = exp_pr.pop_front();
          `CHK("print_data", ex_item, print_data)
        end
      end
      if (break_forward === 1'b1) pulses[0]++;
      if (break_reverse === 1'b1) pulses[1]++;
      if (answerback_start === 1'b1) pulses[2]++;
      if (printer_restore === 1'b1) pulses[3]++;
      if (head_reveal === 1'b1) pulses[4]++;
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc++;
    // Whole run is under a thousand cycles; this only catches a hang
    if (cyc == 20000) begin
      errors++;
      stop_test();
    end
  end

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic latch(input int idx, input logic v);
    keys_raw[idx] <= v;
    repeat (DB + 4) @(posedge mclk);
  endtask

  task automatic press(input int idx);
    latch(idx, 1'b1);
    latch(idx, 1'b0);
  endtask

  task automatic typ(input logic [7:0] c);
    char_key_code <= c;
    char_key_down <= 1'b1;
    repeat (DB + 6) @(posedge mclk);
    char_key_down <= 1'b0;
    repeat (DB + 4) @(posedge mclk);
  endtask

  task automatic drain();
    int k;
    k = 0;
    while ((exp_tx.size() != 0 || exp_pr.size() != 0) && k < 400) begin
      @(posedge mclk);
      k++;
    end
    `CHK("stream_drained", 1'b1, k < 400)
    repeat (4) @(posedge mclk);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(69));
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    bus(1'b0, OFS_STATUS, '0);
    `CHK("status", 32'h0000_0000, rd)
    bus(1'b0, OFS_CTRL, '0);
    `CHK("ctrl", 32'h0000_0000, rd)
    // Any address from 8 up is unmapped and reads zero
    bus(1'b0, {1'b1, 3'($urandom)}, '0);
    `CHK("unmapped", 32'h0000_0000, rd)
    // Remote keyed characters, with and without capitals
    latch(L_CAPS, 1'b1);
    exp_tx.push_back(8'h41);
    exp_pr.push_back('{1'b1, 8'h41});
    typ(8'h61);
    exp_tx.push_back(8'h5A);
    exp_pr.push_back('{1'b1, 8'h5A});
    typ(8'h7A);
    drain();
    latch(L_CAPS, 1'b1);
    i_host.queue_rx(8'h71);
    exp_pr.push_back('{1'b0, 8'h71});
    drain();
    latch(L_CAPS, 1'b0);
    exp_tx.push_back(8'h62);
    exp_pr.push_back('{1'b1, 8'h62});
    typ(8'h62);
    drain();
    // CR with both advance latches, printer stalled so the buffer fills
    latch(L_CRLF, 1'b1);
    latch(L_DOUBLE, 1'b1);
    stall <= 1'b1;
    exp_tx.push_back(CODE_CR);
    exp_pr.push_back('{1'b1, CODE_CR});
    exp_pr.push_back('{1'b0, CODE_LF});
    exp_pr.push_back('{1'b0, CODE_LF});
    typ(CODE_CR);
    repeat (30) @(posedge mclk);
    stall <= 1'b0;
    drain();
    latch(L_CRLF, 1'b0);
    exp_tx.push_back(CODE_LF);
    exp_pr.push_back('{1'b1, CODE_LF});
    exp_pr.push_back('{1'b0, CODE_LF});
    typ(CODE_LF);
    drain();
    latch(L_DOUBLE, 1'b0);
    // Local mode and page advance send nothing
    latch(L_LOCAL, 1'b1);
    exp_pr.push_back('{1'b0, 8'h78});
    typ(8'h78);
    drain();
    latch(L_LOCAL, 1'b0);
    exp_pr.push_back('{1'b0, CODE_FF});
    press(K_PAGE);
    drain();
    // Momentary keys
    press(K_BREAK);
    `CHK("break_forward", 1, pulses[0])
    press(K_ANSWER);
    `CHK("answerback", 1, pulses[2])
    error_detect <= 1'b1;
    @(posedge mclk);
    error_detect <= 1'b0;
    repeat (3) @(posedge mclk);
    `CHK("error_lamp", 1'b1, error_lamp)
    // Fault level is random; the second press takes the other level, so one restore
    rnd = $urandom;
    printer_fault <= rnd[0];
    press(K_RESET);
    `CHK("error_lamp", 1'b0, error_lamp)
    printer_fault <= !rnd[0];
    press(K_RESET);
    `CHK("restore", 1, pulses[3])
    printer_fault <= 1'b0;
    // Line control: carrier sampled on local release; unused control bits random
    rnd = $urandom;
    bus(1'b1, OFS_CTRL, {rnd[31:2], 2'b11});
    bus(1'b0, OFS_CTRL, '0);
    `CHK("ctrl", 32'h0000_0003, rd)
    press(K_BREAK);
    `CHK("break_forward", 2, pulses[0])
    carrier_detect <= 1'b1;
    press(L_LOCAL);
    bus(1'b0, OFS_STATUS, '0);
    `CHK("receiving", 1'b1, rd[ST_RECEIVING])
    press(K_BREAK);
    `CHK("break_reverse", 1, pulses[1])
    `CHK("break_forward", 2, pulses[0])
    carrier_detect <= 1'b0;
    press(L_LOCAL);
    bus(1'b0, OFS_STATUS, '0);
    `CHK("receiving", 1'b0, rd[ST_RECEIVING])
    // Delayed head reveal, then disabled
    latch(L_REVEAL, 1'b1);
    exp_tx.push_back(8'h63);
    exp_pr.push_back('{1'b1, 8'h63});
    typ(8'h63);
    drain();
    repeat (RV + 10) @(posedge mclk);
    `CHK("head_reveal", 1, pulses[4])
    latch(L_REVEAL, 1'b0);
    exp_tx.push_back(8'h64);
    exp_pr.push_back('{1'b1, 8'h64});
    typ(8'h64);
    drain();
    repeat (RV + 10) @(posedge mclk);
    `CHK("head_reveal", 1, pulses[4])
    // Held control key gives one action only
    keys_raw[K_ANSWER] <= 1'b1;
    repeat (80) @(posedge mclk);
    keys_raw[K_ANSWER] <= 1'b0;
    repeat (DB + 4) @(posedge mclk);
    `CHK("answerback", 2, pulses[2])
    // Character key held: first code on press, one repeat once the delay plus one repeat period runs out
    ch = 8'h61 + 8'($urandom % 26);
    exp_tx.push_back(ch);
    exp_pr.push_back('{1'b1, ch});
    exp_tx.push_back(ch);
    exp_pr.push_back('{1'b1, ch});
    char_key_code <= ch;
    char_key_down <= 1'b1;
    repeat (45) @(posedge mclk);
    char_key_down <= 1'b0;
    drain();
    stop_test();
  end
endmodule
`default_nettype wire
